// *** hw/csr_pkg.sv ***
// Constants of the charger status readout bank.
// Assumes one 40 MHz system clock and an 8-bit register read port.
package csr_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CHARGER_STATUS_FIRST = 8'h1d;
    localparam logic [7:0] OFS_CHARGER_STATUS_SECOND = 8'h1e;
    localparam logic [7:0] OFS_FAULT_STATUS = 8'h1f;
    localparam logic [7:0] OFS_CHARGER_EVENT_FLAGS = 8'h20;

    // ----------------------------------------------------------------
    // Reset and unmapped read values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ----------------------------------------------------------------
    // First status and flag register bit positions
    // ----------------------------------------------------------------
    localparam int BIT_ADC_DONE = 6;
    localparam int BIT_DIE_HEAT = 5;
    localparam int BIT_MIN_SYS = 4;
    localparam int BIT_IN_CURRENT = 3;
    localparam int BIT_IN_VOLTAGE = 2;
    localparam int BIT_CHG_TIMER = 1;
    localparam int BIT_HOST_WDOG = 0;
    localparam int EVENT_BITS = 7;

    // ----------------------------------------------------------------
    // Second status register fields
    // ----------------------------------------------------------------
    localparam int POS_CHARGE_PHASE = 3;
    localparam int POS_SOURCE_TYPE = 0;
    localparam logic [1:0] PHASE_IDLE = 2'h0;
    localparam logic [1:0] PHASE_CC = 2'h1;
    localparam logic [1:0] PHASE_CV = 2'h2;
    localparam logic [1:0] PHASE_TOP_OFF = 2'h3;
    localparam logic [2:0] SOURCE_UNKNOWN = 3'h4;

    // ----------------------------------------------------------------
    // Fault status register fields
    // ----------------------------------------------------------------
    localparam int BIT_INPUT_FAULT = 7;
    localparam int BIT_BATTERY_FAULT = 6;
    localparam int BIT_SYS_RAIL_FAULT = 5;
    localparam int BIT_DIE_SHUTDOWN = 3;
    localparam int POS_ZONE = 0;
    localparam logic [2:0] ZONE_NORMAL = 3'h0;
    localparam logic [2:0] ZONE_COLD = 3'h1;
    localparam logic [2:0] ZONE_HOT = 3'h2;
    localparam logic [2:0] ZONE_COOL = 3'h3;
    localparam logic [2:0] ZONE_WARM = 3'h4;
    localparam logic [2:0] ZONE_PRE_COOL = 3'h5;
    localparam logic [2:0] ZONE_PRE_WARM = 3'h6;
    localparam logic [2:0] ZONE_BIAS_FAULT = 3'h7;

    // ----------------------------------------------------------------
    // Synchroniser
    // ----------------------------------------------------------------
    localparam int SYNC_WIDTH = 26;
    localparam logic [SYNC_WIDTH-1:0] SYNC_RST = 26'h000_0000;

endpackage

// *** hw/csr_sync.sv ***
// Two-stage synchroniser for the analog condition inputs.
// Assumes inputs are quasi-static levels from outside the clock domain.
module csr_sync (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [csr_pkg::SYNC_WIDTH-1:0] async_in,
    output logic [csr_pkg::SYNC_WIDTH-1:0] sync_out
);
    import csr_pkg::*;

    logic [SYNC_WIDTH-1:0] stage_one;

    // ----------------------------------------------------------------
    // Two flip-flops per bit
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage_one <= SYNC_RST;
            sync_out <= SYNC_RST;
        end else if (clk_en) begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule // csr_sync

// *** hw/csr_status_bank.sv ***
// Read-only status and event flag registers of the charger.
// Assumes the serial bus engine issues one-cycle reads on clk_sys and
// that condition inputs come from analog circuits, asynchronous.
//
// Overview of operation
// - All bank registers reset zero, read-only
// - Bit 6: one-shot conversion done, zero continuous
// - Bit 5: die thermal regulation active
// - Bit 4: forward mode, battery below minimum system
// - Bit 3: forward input current or pin loop
// - Bit 2: forward input voltage loop active
// - Bit 1: charge safety timer expired
// - Bit 0: host watchdog timer expired
// - Bits 4:3 second register encode charge phase
// - Bits 2:0 report source type, 100b unknown
// - Fault bit 7: input overvoltage or sleep
// - Fault bit 6: battery overcurrent or overvoltage
// - Fault bit 5: system rail short or overvoltage
// - Fault bit 3: die thermal shutdown
// - Fault bits 2:0 encode thermistor zone
// - Code 1 cold or rail absent, 7 bias fault
// - Flag register bits 6:0 latched, bit 7 reserved
// - Flags set on rising edge of condition
// - Thermistor bypass forces normal zone code
module csr_status_bank (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic adc_continuous_mode,
    input wire logic thermistor_bypass,
    input wire logic adc_done_raw,
    input wire logic forward_mode,
    input wire logic die_heat_regulation_status,
    input wire logic min_system_loop_status,
    input wire logic input_current_loop_status,
    input wire logic current_limit_pin,
    input wire logic input_voltage_loop_status,
    input wire logic charge_timer_expired_status,
    input wire logic host_watchdog_expired_status,
    input wire logic [1:0] charge_phase,
    input wire logic [2:0] input_source_type,
    input wire logic input_ovp,
    input wire logic input_sleep,
    input wire logic battery_ocp,
    input wire logic battery_ovp,
    input wire logic system_short,
    input wire logic system_ovp,
    input wire logic die_shutdown_status,
    input wire logic [2:0] thermistor_zone,
    input wire logic thermistor_rail_absent,
    input wire logic thermistor_bias_fault,
    output logic [7:0] charger_status_first,
    output logic [7:0] charger_status_second,
    output logic [7:0] fault_status,
    output logic [7:0] charger_event_flags
);
    import csr_pkg::*;

    // ----------------------------------------------------------------
    // Condition input synchronisation
    // ----------------------------------------------------------------
    logic [SYNC_WIDTH-1:0] raw_bus;
    logic [SYNC_WIDTH-1:0] sync_bus;

    assign raw_bus = {adc_done_raw, forward_mode, die_heat_regulation_status,
                      min_system_loop_status, input_current_loop_status,
                      current_limit_pin, input_voltage_loop_status,
                      charge_timer_expired_status, host_watchdog_expired_status,
                      charge_phase, input_source_type, input_ovp, input_sleep,
                      battery_ocp, battery_ovp, system_short, system_ovp,
                      die_shutdown_status, thermistor_zone,
                      thermistor_rail_absent, thermistor_bias_fault};

    csr_sync u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(raw_bus),
        .sync_out(sync_bus)
    );

    wire s_adc_done = sync_bus[25];
    wire s_forward = sync_bus[24];
    wire s_die_heat = sync_bus[23];
    wire s_min_sys = sync_bus[22];
    wire s_in_current = sync_bus[21];
    wire s_limit_pin = sync_bus[20];
    wire s_in_voltage = sync_bus[19];
    wire s_chg_timer = sync_bus[18];
    wire s_host_wdog = sync_bus[17];
    wire [1:0] s_phase = sync_bus[16:15];
    wire [2:0] s_source = sync_bus[14:12];
    wire s_in_ovp = sync_bus[11];
    wire s_in_sleep = sync_bus[10];
    wire s_bat_ocp = sync_bus[9];
    wire s_bat_ovp = sync_bus[8];
    wire s_sys_short = sync_bus[7];
    wire s_sys_ovp = sync_bus[6];
    wire s_die_shut = sync_bus[5];
    wire s_rail_absent;
    wire s_bias_fault;

    // ----------------------------------------------------------------
    // Zone and rail fault bits share the tail of the bus
    // ----------------------------------------------------------------
    logic [2:0] zone_raw;
    assign zone_raw = sync_bus[4:2];
    assign s_rail_absent = sync_bus[1];
    assign s_bias_fault = sync_bus[0];

    // ----------------------------------------------------------------
    // Live status decode
    // ----------------------------------------------------------------
    wire bit_adc_done = s_adc_done & ~adc_continuous_mode;
    wire bit_min_sys = s_forward & s_min_sys;
    wire bit_in_current = s_forward & (s_in_current | s_limit_pin);
    wire bit_in_voltage = s_forward & s_in_voltage;
    wire [EVENT_BITS-1:0] event_level = {bit_adc_done, s_die_heat, bit_min_sys,
                                         bit_in_current, bit_in_voltage,
                                         s_chg_timer, s_host_wdog};

    logic [2:0] zone_code;
    assign zone_code = thermistor_bypass ? ZONE_NORMAL :
                       s_bias_fault ? ZONE_BIAS_FAULT :
                       s_rail_absent ? ZONE_COLD :
                       zone_raw;

    logic [7:0] next_status_first;
    logic [7:0] next_status_second;
    logic [7:0] next_fault;
    assign next_status_first = {1'b0, event_level};
    assign next_status_second = {3'h0, s_phase, s_source};
    assign next_fault = {s_in_ovp | s_in_sleep,
                         s_bat_ocp | s_bat_ovp,
                         s_sys_short | s_sys_ovp,
                         1'b0,
                         s_die_shut,
                         zone_code};

    // ----------------------------------------------------------------
    // Rising edge event flags
    // ----------------------------------------------------------------
    logic [EVENT_BITS-1:0] event_prev;
    logic [EVENT_BITS-1:0] flag_set;
    logic flag_read;
    logic [7:0] next_flags;
    assign flag_set = event_level & ~event_prev;
    assign flag_read = rd_en && (rd_addr == OFS_CHARGER_EVENT_FLAGS);
    assign next_flags = {1'b0, flag_set | (flag_read ? '0 :
                         charger_event_flags[EVENT_BITS-1:0])};

    // ----------------------------------------------------------------
    // Read data decode
    // ----------------------------------------------------------------
    logic [7:0] read_mux;
    assign read_mux = (rd_addr == OFS_CHARGER_STATUS_FIRST) ? charger_status_first :
                      (rd_addr == OFS_CHARGER_STATUS_SECOND) ? charger_status_second :
                      (rd_addr == OFS_FAULT_STATUS) ? fault_status :
                      (rd_addr == OFS_CHARGER_EVENT_FLAGS) ? charger_event_flags :
                      UNMAPPED_READ;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            charger_status_first <= RST_REG;
            charger_status_second <= RST_REG;
            fault_status <= RST_REG;
            charger_event_flags <= RST_REG;
            event_prev <= '0;
            rd_valid <= 1'b0;
            rd_data <= RST_REG;
        end else if (clk_en) begin
            charger_status_first <= next_status_first;
            charger_status_second <= next_status_second;
            fault_status <= next_fault;
            charger_event_flags <= next_flags;
            event_prev <= event_level;
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= read_mux;
            end
        end
    end

endmodule // csr_status_bank

// *** verification/csr_status_bank_props.sv ***
// Checker for the charger status readout bank.
// Qualifies all but the reserved-bit checks with clk_en, which the bench drops once; sees only the bank's ports.
module csr_status_props (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic adc_continuous_mode,
    input wire logic thermistor_bypass,
    input wire logic die_heat_regulation_status,
    input wire logic die_shutdown_status,
    input wire logic [7:0] charger_status_first,
    input wire logic [7:0] charger_status_second,
    input wire logic [7:0] fault_status,
    input wire logic [7:0] charger_event_flags
);
    import csr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    rsv_bits_zero_a: assert property ((charger_status_first[7] | (|charger_status_second[7:5])
        | fault_status[4]) == 1'b0) else $error("reserved status bit set");
    flag_rsv_zero_a: assert property (charger_event_flags[7] == 1'b0)
        else $error("reserved flag bit set");
    read_answer_a: assert property (rd_en && clk_en |=> rd_valid)
        else $error("read not answered");
    status_read_a: assert property (rd_en && clk_en && rd_addr == OFS_FAULT_STATUS
        |=> rd_data == $past(fault_status)) else $error("fault read mismatch");
    flags_read_a: assert property (rd_en && clk_en && rd_addr == OFS_CHARGER_EVENT_FLAGS
        |=> rd_data == $past(charger_event_flags)) else $error("flag read mismatch");
    unmapped_read_a: assert property (rd_en && clk_en && rd_addr > OFS_CHARGER_EVENT_FLAGS
        |=> rd_data == UNMAPPED_READ) else $error("unmapped read not zero");
    flag_sticky_a: assert property (clk_en && !(rd_en && rd_addr == OFS_CHARGER_EVENT_FLAGS)
        |=> (charger_event_flags & $past(charger_event_flags)) == $past(charger_event_flags))
        else $error("flag lost without read");
    flag_rise_a: assert property ($rose(charger_status_first[BIT_IN_VOLTAGE]) && clk_en
        |-> ##[0:2] charger_event_flags[BIT_IN_VOLTAGE]) else $error("flag not set on rise");
    cont_mode_a: assert property ((adc_continuous_mode && clk_en)[*4]
        |-> !charger_status_first[BIT_ADC_DONE]) else $error("done bit in continuous mode");
    bypass_zone_a: assert property ((thermistor_bypass && clk_en)[*4]
        |-> fault_status[2:0] == ZONE_NORMAL) else $error("zone not normal in bypass");
    heat_live_a: assert property (($stable(die_heat_regulation_status) && clk_en)[*4]
        |-> charger_status_first[BIT_DIE_HEAT] == die_heat_regulation_status)
        else $error("heat bit stale");
    shutdown_live_a: assert property (($stable(die_shutdown_status) && clk_en)[*4]
        |-> fault_status[BIT_DIE_SHUTDOWN] == die_shutdown_status) else $error("shutdown bit stale");
endmodule // csr_status_props
bind csr_status_bank csr_status_props csr_status_props_inst (.clk_sys, .sys_rst, .clk_en,
    .rd_en, .rd_addr, .rd_valid, .rd_data, .adc_continuous_mode, .thermistor_bypass,
    .die_heat_regulation_status, .die_shutdown_status, .charger_status_first,
    .charger_status_second, .fault_status, .charger_event_flags);

// *** verification/csr_host_model.sv ***
// Host side of the read port: one read at a time, pulse then wait.
// Assumes the bank answers one enabled edge after the request.
module csr_host_model (
    input wire logic clk_sys,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic rd_en,
    output logic [7:0] rd_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rd_en = 1'b0;
        rd_addr = 8'hff;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd_en = 1'b0;
        rd_addr = ~a;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
        @(negedge clk_sys);
    endtask
endmodule // csr_host_model

// *** verification/charger_status_readout_bench.sv ***
// Self-checking bench of the charger status bank.
// Assumes a 40 MHz clock and the host model on the read port.
module charger_status_readout_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import csr_pkg::*;
    logic clk_sys, sys_rst, clk_en, rd_en, rd_valid;
    logic [7:0] rd_addr, rd_data, st1, st2, flt, flg, d, ef;
    logic [27:0] v, nv;
    logic [23:0] e, pe;
    logic [31:0] seed;
    logic [7:0] er [5];
    int errors, num_checks, cycles;
    initial clk_sys = 1'b0;
    always #12.5 clk_sys = ~clk_sys;
    function automatic logic [23:0] expect_regs(input logic [27:0] x);
        logic [2:0] z;
        z = x[27] ? ZONE_NORMAL : x[25] ? ZONE_BIAS_FAULT : x[24] ? ZONE_COLD : x[23:21];
        return {x[14] | x[15], x[16] | x[17], x[18] | x[19], 1'b0, x[20], z,
            3'b000, x[10:9], x[13:11], 1'b0, x[0] & ~x[26], x[2], x[1] & x[3],
            x[1] & (x[4] | x[5]), x[1] & x[6], x[7], x[8]};
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] x);
        num_checks++;
        if (s !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    csr_status_bank csr_status_bank_inst (.clk_sys, .sys_rst, .clk_en, .rd_en, .rd_addr,
        .rd_valid, .rd_data, .adc_continuous_mode(v[26]), .thermistor_bypass(v[27]),
        .adc_done_raw(v[0]), .forward_mode(v[1]), .die_heat_regulation_status(v[2]),
        .min_system_loop_status(v[3]), .input_current_loop_status(v[4]),
        .current_limit_pin(v[5]), .input_voltage_loop_status(v[6]),
        .charge_timer_expired_status(v[7]), .host_watchdog_expired_status(v[8]),
        .charge_phase(v[10:9]), .input_source_type(v[13:11]), .input_ovp(v[14]),
        .input_sleep(v[15]), .battery_ocp(v[16]), .battery_ovp(v[17]), .system_short(v[18]),
        .system_ovp(v[19]), .die_shutdown_status(v[20]), .thermistor_zone(v[23:21]),
        .thermistor_rail_absent(v[24]), .thermistor_bias_fault(v[25]),
        .charger_status_first(st1), .charger_status_second(st2), .fault_status(flt),
        .charger_event_flags(flg));
    csr_host_model csr_host_model_inst (.clk_sys, .rd_valid, .rd_data, .rd_en, .rd_addr);
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        v = 28'h000_0000;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        ef = 8'h00;
        seed = 32'h0001_1620;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("reset", {st1 | st2 | flt | flg}, RST_REG);
        for (int i = 0; i < 60; i++) begin
            repeat (8) seed = lfsr(seed);
            nv = seed[27:0];
            if (nv[26] != v[26]) nv[0] = v[0];
            if (i < 8) nv[27:21] = {4'h0, 3'(i)};
            pe = expect_regs(v);
            e = expect_regs(nv);
            ef = ef | ({1'b0, e[6:0]} & ~{1'b0, pe[6:0]});
            if (i == 30) clk_en = 1'b0;
            v = nv;
            repeat (5) @(negedge clk_sys);
            if (i == 30) begin
                check("frozen", st1, pe[7:0]);
                clk_en = 1'b1;
                repeat (5) @(negedge clk_sys);
            end
            e = expect_regs(v);
            check("first", st1, e[7:0]);
            check("second", st2, e[15:8]);
            check("fault", flt, e[23:16]);
            check("flags", flg, ef);
            er = '{e[7:0], e[15:8], e[23:16], ef, UNMAPPED_READ};
            for (int k = 0; k < 5; k++) begin
                csr_host_model_inst.rd(OFS_CHARGER_STATUS_FIRST + 8'(k), d);
                check("read", d, er[k]);
            end
            ef = 8'h00;
        end
        conclude();
    end
endmodule // charger_status_readout_bench
